// File: rtl/hub_pin_defs.svh
// Purpose: constants for the shared suspend / strap / power-sense pin block
// Assumes: 20 MHz system clock
// Notes:   definitions only
`ifndef HUB_PIN_DEFS_SVH
`define HUB_PIN_DEFS_SVH

// ---------------------------------------------------------------------------
// fixed-port strap codes
// ---------------------------------------------------------------------------
`define FIXED_CODE_NONE     2'h0
`define FIXED_CODE_PORT1    2'h1
`define FIXED_CODE_PORT12   2'h2
`define FIXED_CODE_RSVD     2'h3
`define FIXED_CODE_RST      2'h0

// ---------------------------------------------------------------------------
// register offsets and fields
// ---------------------------------------------------------------------------
`define REG_CTRL            4'h0
`define REG_STATUS          4'h1
`define CTRL_ACTIVE_BIT     0
`define CTRL_CONFIGURED_BIT 1
`define CTRL_DYNAMIC_BIT    2
`define CTRL_ATTACH_BIT     3
`define CTRL_RST            8'h00

// ---------------------------------------------------------------------------
// timing: clock period and the reset pulse the system must give
// ---------------------------------------------------------------------------
`define CLK_PERIOD_NS       50
`define RESET_MIN_NS        1000
`define RESET_MIN_CYCLES    ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/hub_pin_pkg.sv
// Purpose: types for the shared pin block
// Assumes: nothing
// Notes:   numbers live in hub_pin_defs.svh
package hub_pin_pkg;
   typedef enum logic [1:0] {
      PHASE_RESET,
      PHASE_SAMPLE,
      PHASE_RUN
   } phase_t;

   typedef enum logic [1:0] {
      MODE_STRAP,
      MODE_SERIAL
   } cfg_mode_t;
endpackage

// File: rtl/hub_pin_if.sv
// Purpose: carrier between the top module and the strap sampler
// Assumes: one clock
// Notes:   sampler owns latched values
`timescale 1ns/100ps
`default_nettype none
interface hub_pin_if;
   logic       sample;
   logic       strap_lo;
   logic       strap_hi;
   logic       cfg_sel;
   logic       power_sense;
   logic       attached;
   logic [1:0] fixed_port_code;
   logic       serial_cfg;
   logic       self_power;
   logic       valid;

   modport top
   (
      output sample,
      output strap_lo,
      output strap_hi,
      output cfg_sel,
      output power_sense,
      output attached,
      input  fixed_port_code,
      input  serial_cfg,
      input  self_power,
      input  valid
   );

   modport sampler
   (
      input  sample,
      input  strap_lo,
      input  strap_hi,
      input  cfg_sel,
      input  power_sense,
      input  attached,
      output fixed_port_code,
      output serial_cfg,
      output self_power,
      output valid
   );
endinterface
`default_nettype wire

// File: rtl/hub_strap_sampler.sv
// Purpose: catches strap and power-sense levels once after reset release
// Assumes: i_sample is a one-cycle pulse in the second cycle after release
// Notes:   in serial mode power sense keeps tracking until attach, then freezes; in strap mode it is taken once
`timescale 1ns/100ps
`default_nettype none
module hub_strap_sampler
   import hub_pin_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst,
   hub_pin_if.sampler bus
);
`include "hub_pin_defs.svh"

   typedef struct packed {
      logic [1:0] code;
      logic       serial;
      logic       self_pwr;
      logic       valid;
   } samp_state_t;

   samp_state_t state;
   samp_state_t next_state;

   always_comb
   begin
      next_state = state;
      if (bus.sample)
      begin
         next_state.code   = {bus.strap_hi, bus.strap_lo};
         next_state.serial = bus.cfg_sel;
         next_state.valid  = 1'b1;
         next_state.self_pwr = bus.power_sense;
      end
      else if (state.valid && state.serial && !bus.attached)
      begin
         // before attach the level may still be re-read; frozen after
         next_state.self_pwr = bus.power_sense;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= '{code: `FIXED_CODE_RST, serial: 1'b0, self_pwr: 1'b0, valid: 1'b0};
      end
      else
      begin
         state <= next_state;
      end
   end

   assign bus.fixed_port_code = state.code;
   assign bus.serial_cfg      = state.serial;
   assign bus.self_power      = state.self_pwr;
   assign bus.valid           = state.valid;

   AST_CODE_HELD: assert property (@(posedge i_clk) disable iff (i_rst)
      state.valid && !bus.sample |=> $stable(state.code) && $stable(state.serial))
      else $error("sampled strap changed without reset");

   AST_SENSE_FROZEN: assert property (@(posedge i_clk) disable iff (i_rst)
      state.valid && bus.attached && !bus.sample |=> $stable(state.self_pwr))
      else $error("power sense changed after attach");

   AST_CODE_TAKEN: assert property (@(posedge i_clk) disable iff (i_rst)
      bus.sample |=> state.code == $past({bus.strap_hi, bus.strap_lo}))
      else $error("strap code not taken at release");
endmodule
`default_nettype wire

// File: rtl/hub_pin_mux.sv
// What this block does
// - at reset release sample two straps as fixed-port code; 11 reserved
// - suspend indicator high only while configured and active
// - strap mode: pin is strap low bit in reset, suspend output after
// - pin is power sense input only in serial-configured mode
// - dynamic switching: sense low reports bus power, high self power
// - sense sampled at reset, in serial mode re-read until attach bit is set, then frozen
// - configuration select latched at reset release picks strap or serial mode
//
// Purpose: shared suspend / strap / power-sense pin and its reset sampling
// Assumes: registers over a plain strobe port, read data one cycle later
// Notes:   pin is three signals; enable low means driving
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module hub_pin_mux
   import hub_pin_pkg::*;
(
   input  wire logic       I_CLK_SYS,
   input  wire logic       I_RST,
   input  wire logic       I_PIN_IN,
   output logic            O_PIN_OUT,
   output logic            O_PIN_OE_N,
   input  wire logic       I_STRAP_HI,
   input  wire logic       I_CFG_SEL,
   input  wire logic [3:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output logic [7:0]      O_RDATA,
   output logic [1:0]      O_FIXED_PORT_CODE,
   output logic            O_FIXED_CODE_RSVD,
   output logic            O_SELF_POWERED,
   output logic            O_SERIAL_CFG
);
`include "hub_pin_defs.svh"

// ---------------------------------------------------------------------------
// state
// ---------------------------------------------------------------------------
   typedef struct packed {
      phase_t     phase;
      logic [7:0] ctrl;
      logic [7:0] rdata;
      logic       pin_out;
      logic       pin_oe_n;
      logic [1:0] code;
      logic       rsvd;
      logic       self_pwr;
      logic       serial;
   } top_state_t;

   top_state_t state;
   top_state_t next_state;
   hub_pin_if  pins();

   logic configured;
   logic active;
   logic dynamic_en;
   logic attached;

   assign configured = state.ctrl[`CTRL_CONFIGURED_BIT];
   assign active     = state.ctrl[`CTRL_ACTIVE_BIT];
   assign dynamic_en = state.ctrl[`CTRL_DYNAMIC_BIT];
   assign attached   = state.ctrl[`CTRL_ATTACH_BIT];

// ---------------------------------------------------------------------------
// reset sampling
// ---------------------------------------------------------------------------
   assign pins.sample      = (state.phase == PHASE_SAMPLE);
   assign pins.strap_lo    = I_PIN_IN;
   assign pins.strap_hi    = I_STRAP_HI;
   assign pins.cfg_sel     = I_CFG_SEL;
   assign pins.power_sense = I_PIN_IN;
   assign pins.attached    = attached;

   hub_strap_sampler u_sampler
   (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RST),
      .bus   (pins.sampler)
   );

// ---------------------------------------------------------------------------
// next state
// ---------------------------------------------------------------------------
   always_comb
   begin
      next_state       = state;
      next_state.rdata = 8'h00;
      unique case (state.phase)
         PHASE_RESET:
         begin
            // pin stays an input so the strap resistor sets the level
            next_state.phase = PHASE_SAMPLE;
         end
         PHASE_SAMPLE:
         begin
            next_state.phase = PHASE_RUN;
         end
         PHASE_RUN:
         begin
            next_state.phase = PHASE_RUN;
         end
      endcase

      if (pins.valid)
      begin
         next_state.code   = pins.fixed_port_code;
         next_state.rsvd   = (pins.fixed_port_code == `FIXED_CODE_RSVD);
         next_state.serial = pins.serial_cfg;
         // bus power when sense low, self power when high
         next_state.self_pwr = pins.serial_cfg && dynamic_en && pins.self_power;
      end

      if (pins.valid && !pins.serial_cfg)
      begin
         next_state.pin_oe_n = 1'b0;
         next_state.pin_out  = configured && active;
      end
      else
      begin
         // serial mode: pin is the power sense input, never driven
         next_state.pin_oe_n = 1'b1;
         next_state.pin_out  = 1'b0;
      end

      if (I_WR && I_ADDR == `REG_CTRL)
      begin
         next_state.ctrl = I_WDATA;
         // attach is one-way until reset
         next_state.ctrl[`CTRL_ATTACH_BIT] = I_WDATA[`CTRL_ATTACH_BIT] | attached;
      end

      if (I_RD)
      begin
         unique case (I_ADDR)
            `REG_CTRL:   next_state.rdata = state.ctrl;
            `REG_STATUS: next_state.rdata = {3'h0, state.serial, state.self_pwr,
                                             state.rsvd, state.code};
            default:     next_state.rdata = 8'h00;
         endcase
      end
   end

// ---------------------------------------------------------------------------
// registers
// ---------------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         state <= '{phase: PHASE_RESET, ctrl: `CTRL_RST, rdata: 8'h00, pin_out: 1'b0,
                    pin_oe_n: 1'b1, code: `FIXED_CODE_RST, rsvd: 1'b0, self_pwr: 1'b0,
                    serial: 1'b0};
      end
      else
      begin
         state <= next_state;
      end
   end

   assign O_PIN_OUT         = state.pin_out;
   assign O_PIN_OE_N        = state.pin_oe_n;
   assign O_RDATA           = state.rdata;
   assign O_FIXED_PORT_CODE = state.code;
   assign O_FIXED_CODE_RSVD = state.rsvd;
   assign O_SELF_POWERED    = state.self_pwr;
   assign O_SERIAL_CFG      = state.serial;

// ---------------------------------------------------------------------------
// checks
// ---------------------------------------------------------------------------
   sequence run_strap_mode;
      state.phase == PHASE_RUN && !pins.serial_cfg && pins.valid;
   endsequence

   AST_SUSP_OFF: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      run_strap_mode ##1 !state.pin_oe_n |-> state.pin_out == $past(configured && active))
      else $error("suspend indicator does not follow hub state");

   AST_STRAP_DRIVE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      run_strap_mode |=> !state.pin_oe_n)
      else $error("strap mode pin not driven after reset");

   AST_PIN_INPUT_RESET: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state.phase != PHASE_RUN |-> state.pin_oe_n)
      else $error("pin driven while strap is sampled");

   AST_SERIAL_INPUT: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state.serial |-> state.pin_oe_n && !state.pin_out)
      else $error("pin driven in serial mode");

   AST_POWER_REPORT: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state.self_pwr |-> state.serial && $past(dynamic_en))
      else $error("self power reported without dynamic switching");

   AST_ATTACH_STICKY: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      attached |=> attached)
      else $error("attach bit cleared without reset");

   AST_RSVD_FLAG: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state.rsvd == (state.code == `FIXED_CODE_RSVD))
      else $error("reserved flag mismatch");

   AST_SERIAL_HELD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      pins.valid ##1 pins.valid |=> $stable(state.serial))
      else $error("configuration select changed after release");

// ---------------------------------------------------------------------------
// checks on indicator, power report, sampled code and mode, and phases
// ---------------------------------------------------------------------------
   sequence strap_pin_driven;
      !state.pin_oe_n && !state.serial;
   endsequence

   sequence hub_running;
      $past(configured) && $past(active);
   endsequence

   // sense already frozen one edge before, so the report cannot move
   sequence attached_dyn;
      pins.valid && attached && dynamic_en;
   endsequence

   AST_SUSP_CAUSE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state.pin_out
      |-> $past(configured) && $past(active))
      else $error("suspend indicator high without an active configured hub");

   AST_SUSP_UNCONF: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      strap_pin_driven ##0 !$past(configured)
      |-> !state.pin_out)
      else $error("suspend indicator high while unconfigured");

   AST_SUSP_SUSPENDED: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      strap_pin_driven ##0 !$past(active)
      |-> !state.pin_out)
      else $error("suspend indicator high while suspended");

   AST_SUSP_ACTIVE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      strap_pin_driven ##0 hub_running
      |-> state.pin_out)
      else $error("suspend indicator low while hub active");

   AST_DRIVE_STRAP_ONLY: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      !state.pin_oe_n
      |-> !state.serial)
      else $error("pin driven although serial-configured");

   AST_SELF_PWR_SET: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      pins.valid && pins.serial_cfg && dynamic_en && pins.self_power
      |=> state.self_pwr)
      else $error("sense high but bus power reported");

   AST_BUS_PWR_LOW: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      pins.valid && dynamic_en && !pins.self_power
      |=> !state.self_pwr)
      else $error("sense low but self power reported");

   AST_BUS_PWR_STATIC: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      pins.valid && !dynamic_en
      |=> !state.self_pwr)
      else $error("self power reported with dynamic switching off");

   AST_STRAP_NO_SENSE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      pins.valid && !pins.serial_cfg
      |=> !state.self_pwr)
      else $error("power sense used in strap mode");

   AST_CODE_COPY: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      pins.valid
      |=> state.code == $past(pins.fixed_port_code))
      else $error("fixed-port code output differs from sampled code");

   AST_SERIAL_COPY: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      pins.valid
      |=> state.serial == $past(pins.serial_cfg))
      else $error("mode output differs from latched select");

   AST_CODE_KEPT: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      pins.valid ##1 pins.valid
      |=> $stable(state.code) && $stable(state.rsvd))
      else $error("fixed-port code moved without reset");

   AST_SENSE_KEPT: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      attached_dyn ##1 attached_dyn
      |=> $stable(state.self_pwr))
      else $error("power report moved after attach");

   AST_PHASE_SAMPLE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state.phase == PHASE_RESET
      |=> state.phase == PHASE_SAMPLE)
      else $error("sample phase skipped after release");

   AST_PHASE_RUN: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      state.phase == PHASE_SAMPLE
      |=> state.phase == PHASE_RUN && pins.valid)
      else $error("straps not captured in the sample phase");
endmodule
`default_nettype wire

// File: sim/hub_board_model.sv
// Purpose: board side of the shared pin: pull resistor level
// Assumes: pull level serves as strap low bit and power sense
// Notes:   board level is seen only while the block releases the pin
`timescale 1ns/100ps
`default_nettype none
module hub_board_model
(
   input  wire logic i_pin_out,
   input  wire logic i_pin_oe_n,
   input  wire logic i_pull_lvl,
   output logic      o_pin_in
);
   assign o_pin_in = i_pin_oe_n ? i_pull_lvl : i_pin_out;
endmodule
`default_nettype wire

// File: sim/hub_pin_mux_tb_top.sv
// Purpose: self-checking bench for the shared suspend / strap pin block
// Assumes: outputs settle two edges after a register write
// Notes:   all waits are fixed counts; a watchdog bounds the run
`timescale 1ns/100ps
`default_nettype none
`include "hub_pin_defs.svh"
module hub_pin_mux_tb_top
   import hub_pin_pkg::*;
;
   logic       clk;
   logic       rst;
   logic       pull_lvl;
   logic       strap_hi;
   logic       cfg_sel;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       pin_out;
   logic       pin_oe_n;
   logic       pin_in;
   logic [1:0] fixed_code;
   logic       rsvd;
   logic       self_pwr;
   logic       serial_cfg;
   int         err_total;
   int         num_checks;
   logic [7:0] ctl [5] = '{8'h03, 8'h02, 8'h01, 8'h03, 8'h00};
   logic [7:0] ind [5] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00};

   hub_pin_mux i_dut
   (
      .I_CLK_SYS         (clk),
      .I_RST             (rst),
      .I_PIN_IN          (pin_in),
      .O_PIN_OUT         (pin_out),
      .O_PIN_OE_N        (pin_oe_n),
      .I_STRAP_HI        (strap_hi),
      .I_CFG_SEL         (cfg_sel),
      .I_ADDR            (addr),
      .I_WDATA           (wdata),
      .I_WR              (wr),
      .I_RD              (rd),
      .O_RDATA           (rdata),
      .O_FIXED_PORT_CODE (fixed_code),
      .O_FIXED_CODE_RSVD (rsvd),
      .O_SELF_POWERED    (self_pwr),
      .O_SERIAL_CFG      (serial_cfg)
   );

   hub_board_model i_board
   (
      .i_pin_out  (pin_out),
      .i_pin_oe_n (pin_oe_n),
      .i_pull_lvl (pull_lvl),
      .o_pin_in   (pin_in)
   );

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic do_reset(input logic cfg, input logic lo, input logic hi);
      @(posedge clk);
      rst <= 1'b1;
      cfg_sel <= cfg;
      pull_lvl <= lo;
      strap_hi <= hi;
      // 21 cycles here plus the release edge: two past the 20-cycle minimum pulse width
      repeat (`RESET_MIN_CYCLES + 1) @(posedge clk);
      #1;
      check({6'h00, pin_oe_n, pin_out}, 8'h02);
      @(posedge clk);
      rst <= 1'b0;
      tick(4);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      tick(2);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   task automatic set_pull(input logic v);
      @(posedge clk);
      pull_lvl <= v;
      tick(3);
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog, sequence
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("ERROR %0t: timeout", $time);
      summarize();
   end

   initial
   begin
      err_total = 0;
      num_checks = 0;
      rst = 1'b1;
      pull_lvl = 1'b0;
      strap_hi = 1'b0;
      cfg_sel = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      for (int c = 0; c < 4; c++)
      begin
         do_reset(1'b0, c[0], c[1]);
         check({6'h00, fixed_code}, {6'h00, c[1:0]});
         check({7'h00, rsvd}, {7'h00, &c[1:0]});
         check({6'h00, pin_oe_n, serial_cfg}, 8'h00);
         rd_chk(`REG_STATUS, {5'h00, &c[1:0], c[1:0]});
         @(posedge clk);
         strap_hi <= ~c[1];
         cfg_sel <= 1'b1;
         tick(3);
         check({6'h00, fixed_code}, {6'h00, c[1:0]});
         check({7'h00, serial_cfg}, 8'h00);
      end
      $display("test strap codes done");
      for (int k = 0; k < 5; k++)
      begin
         wr_reg(`REG_CTRL, ctl[k]);
         check({7'h00, pin_out}, ind[k]);
      end
      wr_reg(`REG_CTRL, 8'h04);
      check({7'h00, self_pwr}, 8'h00);
      $display("test suspend indicator done");
      do_reset(1'b1, 1'b1, 1'b0);
      check({6'h00, pin_oe_n, serial_cfg}, 8'h03);
      wr_reg(`REG_CTRL, 8'h03);
      check({6'h00, pin_oe_n, self_pwr}, 8'h02);
      wr_reg(`REG_CTRL, 8'h04);
      check({7'h00, self_pwr}, 8'h01);
      set_pull(1'b0);
      check({7'h00, self_pwr}, 8'h00);
      set_pull(1'b1);
      wr_reg(`REG_CTRL, 8'h0C);
      set_pull(1'b0);
      check({7'h00, self_pwr}, 8'h01);
      wr_reg(`REG_CTRL, 8'h04);
      check({7'h00, self_pwr}, 8'h01);
      rd_chk(`REG_CTRL, 8'h0C);
      wr_reg(`REG_CTRL, 8'h08);
      check({7'h00, self_pwr}, 8'h00);
      @(posedge clk);
      cfg_sel <= 1'b0;
      tick(3);
      check({7'h00, serial_cfg}, 8'h01);
      $display("test power sense done");
      wr_reg(4'hF, 8'hFF);
      rd_chk(4'hF, 8'h00);
      rd_chk(`REG_CTRL, 8'h08);
      $display("test unmapped access done");
      summarize();
   end
endmodule
`default_nettype wire
